// >>> rtl/idw_defs.vh
// idw_defs.vh: constants for the identification word builder
// assumes inclusion by bare name from rtl/ design files
`ifndef IDW_DEFS_VH
`define IDW_DEFS_VH
// identification word indices
`define IDW_W51 8'h33
`define IDW_W53 8'h35
`define IDW_W62 8'h3E
`define IDW_W63 8'h3F
`define IDW_W64 8'h40
`define IDW_W65 8'h41
`define IDW_W66 8'h42
`define IDW_W67 8'h43
`define IDW_W68 8'h44
`define IDW_W69 8'h45
`define IDW_W70 8'h46
`define IDW_W71 8'h47
`define IDW_W72 8'h48
`define IDW_W73 8'h49
`define IDW_VS_LO 8'h80
`define IDW_VS_HI 8'h9F
`define IDW_LAST 8'hFF
// opcode of the dma identify command
`define IDW_OP_ID_DMA 8'hEE
// field codes
`define IDW_ZERO16 16'h0000
`define IDW_ALL16 16'hFFFF
`define IDW_IF_REG 16'h0100
`define IDW_IF_PKT 16'h0200
`define IDW_MAJ_MASK 16'h000E
`define IDW_ADV_MASK 8'h03
`define IDW_VALID_BIT 1
`define IDW_MW1_MASK 8'hFE
// apb register byte addresses
`define IDW_A_SWDMA 12'h000
`define IDW_A_MWDMA 12'h004
`define IDW_A_PIO 12'h008
`define IDW_A_MWMIN 12'h00C
`define IDW_A_MWREC 12'h010
`define IDW_A_PIONF 12'h014
`define IDW_A_PIOFC 12'h018
`define IDW_A_VER 12'h01C
`define IDW_A_MINOR 12'h020
`define IDW_A_CTRL 12'h024
`define IDW_A_STAT 12'h028
`define IDW_A_W53 12'h02C
// reset values
`define IDW_RST_SWDMA 16'h0107
`define IDW_RST_MWDMA 16'h0407
`define IDW_RST_PIO 16'h0203
`define IDW_RST_MWMIN 16'h0078
`define IDW_RST_MWREC 16'h0078
`define IDW_RST_PIONF 16'h00B4
`define IDW_RST_PIOFC 16'h0078
`define IDW_RST_IF 16'h0100
`define IDW_RST_MAJ 16'h000E
`define IDW_RST_MINOR 16'h0008
`endif

// >>> rtl/idw_sync.v
// idw_sync.v: two flip-flop synchroniser for pin levels
// assumes a single clk domain, async active-low reset
`timescale 1ns/1ps
`include "idw_defs.vh"
module idw_sync (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// level in and out
	input wire d,
	output reg q_r
);
	reg meta_r;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= 1'b0;
			q_r <= 1'b0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end
endmodule // idw_sync

// >>> rtl/idw_table.v
// idw_table.v: identification words 51, 53 and 62..255 builder and dma streamer
// assumes an apb master on clk and a host dma engine with dmack pin
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "idw_defs.vh"
module idw_table (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// command port
	input wire cmd_valid,
	input wire [7:0] cmd_opcode,
	output wire cmd_ready,
	// lower words 0..61 except 51/53, from the core
	output wire [7:0] low_idx,
	input wire [15:0] low_word,
	// dma pins
	output reg dmarq_r,
	input wire dmack_b,
	input wire dma_pause,
	output reg [15:0] dma_data_r,
	output reg dma_strobe_r,
	output wire busy
);
	localparam ST_IDLE = 2'b00;
	localparam ST_REQ = 2'b01;
	localparam ST_XFER = 2'b10;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [15:0] swdma_r;
	reg [15:0] mwdma_r;
	reg [15:0] pio_r;
	reg [15:0] mwmin_r;
	reg [15:0] mwrec_r;
	reg [15:0] pionf_r;
	reg [15:0] piofc_r;
	reg [15:0] iftype_r;
	reg [15:0] major_r;
	reg [15:0] minor_r;
	reg [15:0] vendor_r;
	reg [7:0] idx_r;
	reg [7:0] idx_nxt;
	reg [15:0] done_cnt_r;
	wire ack_s;
	wire ack;
	wire [15:0] w53;
	wire [15:0] hi_word;
	wire [15:0] cur_word;
	wire mw_fast;
	wire adv_pio;
	wire valid_fields;
	wire wr_en;
	wire acc;
	wire mapped;
	idw_sync u_ack (
		.clk(clk),
		.rst_b(rst_b),
		.d(~dmack_b),
		.q_r(ack_s)
	);
	assign ack = ack_s;
	// support checks drive the field validity bit
	assign mw_fast = |(mwdma_r[7:0] & `IDW_MW1_MASK);
	assign adv_pio = |(pio_r[7:0] & `IDW_ADV_MASK);
	assign valid_fields = mw_fast | adv_pio | (|mwmin_r) | (|mwrec_r)
		| (|pionf_r) | (|piofc_r);
	assign w53 = {14'h0000, valid_fields, 1'b0};
	idw_word_mux u_mux (
		.idx(idx_r),
		.swdma(swdma_r),
		.mwdma(mwdma_r),
		.pio(pio_r),
		.mwmin(mwmin_r),
		.mwrec(mwrec_r),
		.pionf(pionf_r),
		.piofc(piofc_r),
		.iftype(iftype_r),
		.major(major_r),
		.minor(minor_r),
		.w53(w53),
		.vendor(vendor_r),
		.word(hi_word)
	);
	assign low_idx = idx_r;
	assign cur_word = (idx_r < `IDW_W62 && idx_r != `IDW_W51 && idx_r != `IDW_W53)
		? low_word : hi_word;
	// apb decode
	assign acc = psel & penable;
	assign wr_en = acc & pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr <= `IDW_A_W53) && (paddr[1:0] == 2'b00);
	assign pslverr = acc & ~mapped;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			swdma_r <= `IDW_RST_SWDMA;
			mwdma_r <= `IDW_RST_MWDMA;
			pio_r <= `IDW_RST_PIO;
			mwmin_r <= `IDW_RST_MWMIN;
			mwrec_r <= `IDW_RST_MWREC;
			pionf_r <= `IDW_RST_PIONF;
			piofc_r <= `IDW_RST_PIOFC;
			iftype_r <= `IDW_RST_IF;
			major_r <= `IDW_RST_MAJ;
			minor_r <= `IDW_RST_MINOR;
			vendor_r <= `IDW_ZERO16;
		end else if (wr_en) begin
			case (paddr)
				`IDW_A_SWDMA: swdma_r <= pwdata[15:0];
				`IDW_A_MWDMA: mwdma_r <= pwdata[15:0];
				`IDW_A_PIO: pio_r <= {pwdata[15:8], 6'h00, pwdata[1:0]};
				`IDW_A_MWMIN: mwmin_r <= pwdata[15:0];
				`IDW_A_MWREC: mwrec_r <= pwdata[15:0];
				`IDW_A_PIONF: pionf_r <= pwdata[15:0];
				`IDW_A_PIOFC: piofc_r <= pwdata[15:0];
				`IDW_A_VER: begin
					iftype_r <= pwdata[15:0];
					major_r <= pwdata[31:16];
				end
				`IDW_A_MINOR: begin
					minor_r <= pwdata[15:0];
					vendor_r <= pwdata[31:16];
				end
				default: begin
				end
			endcase
		end
	end
	always @* begin
		case (paddr)
			`IDW_A_SWDMA: prdata = {16'h0000, swdma_r};
			`IDW_A_MWDMA: prdata = {16'h0000, mwdma_r};
			`IDW_A_PIO: prdata = {16'h0000, pio_r};
			`IDW_A_MWMIN: prdata = {16'h0000, mwmin_r};
			`IDW_A_MWREC: prdata = {16'h0000, mwrec_r};
			`IDW_A_PIONF: prdata = {16'h0000, pionf_r};
			`IDW_A_PIOFC: prdata = {16'h0000, piofc_r};
			`IDW_A_VER: prdata = {major_r, iftype_r};
			`IDW_A_MINOR: prdata = {vendor_r, minor_r};
			`IDW_A_CTRL: prdata = {done_cnt_r, 8'h00, idx_r};
			`IDW_A_STAT: prdata = {30'h00000000, state_r};
			`IDW_A_W53: prdata = {16'h0000, w53};
			default: prdata = 32'h00000000;
		endcase
	end
	// identify stream
	assign cmd_ready = (state_r == ST_IDLE);
	assign busy = (state_r != ST_IDLE);
	always @* begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		case (state_r)
			ST_IDLE: begin
				if (cmd_valid && cmd_opcode == `IDW_OP_ID_DMA) begin
					state_nxt = ST_REQ;
					idx_nxt = 8'h00;
				end
			end
			ST_REQ: begin
				if (ack)
					state_nxt = ST_XFER;
			end
			ST_XFER: begin
				if (!dma_pause) begin
					if (idx_r == `IDW_LAST)
						state_nxt = ST_IDLE;
					else
						idx_nxt = idx_r + 8'h01;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			idx_r <= 8'h00;
			dmarq_r <= 1'b0;
			dma_data_r <= `IDW_ZERO16;
			dma_strobe_r <= 1'b0;
			done_cnt_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			dmarq_r <= (state_nxt != ST_IDLE) & ~dma_pause;
			dma_strobe_r <= (state_r == ST_XFER) & ~dma_pause;
			if (state_r == ST_XFER && !dma_pause)
				dma_data_r <= cur_word;
			if (state_r == ST_XFER && idx_r == `IDW_LAST && !dma_pause)
				done_cnt_r <= done_cnt_r + 16'h0001;
		end
	end
endmodule // idw_table

// >>> rtl/idw_word_mux.v
// idw_word_mux.v: combinational table lookup for one word index
// assumes settings come from registers on the same clock
`timescale 1ns/1ps
`include "idw_defs.vh"
module idw_word_mux (
	// index
	input wire [7:0] idx,
	// settings
	input wire [15:0] swdma,
	input wire [15:0] mwdma,
	input wire [15:0] pio,
	input wire [15:0] mwmin,
	input wire [15:0] mwrec,
	input wire [15:0] pionf,
	input wire [15:0] piofc,
	input wire [15:0] iftype,
	input wire [15:0] major,
	input wire [15:0] minor,
	input wire [15:0] w53,
	input wire [15:0] vendor,
	// word out
	output reg [15:0] word
);
	always @* begin
		case (idx)
			`IDW_W51: word = {pio[15:8], 8'h00};
			`IDW_W53: word = w53;
			`IDW_W62: word = swdma;
			`IDW_W63: word = mwdma;
			`IDW_W64: word = {8'h00, pio[7:0] & `IDW_ADV_MASK};
			`IDW_W65: word = mwmin;
			`IDW_W66: word = mwrec;
			`IDW_W67: word = pionf;
			`IDW_W68: word = piofc;
			`IDW_W69: word = `IDW_ZERO16;
			`IDW_W70: word = `IDW_ZERO16;
			`IDW_W71: word = iftype;
			`IDW_W72: word = major;
			`IDW_W73: word = minor;
			default: begin
				if (idx >= `IDW_VS_LO && idx <= `IDW_VS_HI)
					word = vendor;
				else
					word = `IDW_ZERO16;
			end
		endcase
	end
endmodule // idw_word_mux

// >>> sim/idw_host.sv
// idw_host.sv: host adapter model on the dma pins
// assumes dmarq_r from idw_table on the same clk
`timescale 1ns/1ps
module idw_host (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// dma pins and mode
	input wire dmarq_r,
	input wire slow,
	output reg dmack_b,
	output reg dma_pause
);
	reg [1:0] ph_r;
	reg [1:0] lo_r;
	// ack on request, release after three quiet cycles
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dmack_b <= 1'b1;
			dma_pause <= 1'b0;
			ph_r <= 2'h0;
			lo_r <= 2'h3;
		end else begin
			ph_r <= ph_r + 2'h1;
			lo_r <= dmarq_r ? 2'h0 : (lo_r == 2'h3 ? lo_r : lo_r + 2'h1);
			dmack_b <= dmarq_r ? 1'b0 : (lo_r == 2'h3 ? 1'b1 : dmack_b);
			dma_pause <= slow && dmarq_r && !dmack_b && ph_r == 2'h0;
		end
	end
endmodule // idw_host

// >>> sim/idw_table_monitor.sv
// idw_table_monitor.sv: port assertions for idw_table
// assumes one clk domain, bound to every idw_table
`timescale 1ns/1ps
module idw_mon (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// apb
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	// command and dma
	input wire cmd_valid,
	input wire [7:0] cmd_opcode,
	input wire cmd_ready,
	input wire [7:0] low_idx,
	input wire dmarq_r,
	input wire dmack_b,
	input wire dma_pause,
	input wire dma_strobe_r,
	input wire busy
);
	reg [8:0] wcnt_r;
	wire go = cmd_valid && cmd_ready && cmd_opcode == 8'hEE;
	wire acc = psel && penable;
	wire bad = paddr > 12'h02C || paddr[1:0] != 2'h0;
	wire hold = dma_pause && busy && !dmack_b;
	// strobes since the last accepted dma identify command
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			wcnt_r <= 9'h000;
		else if (go)
			wcnt_r <= 9'h000;
		else if (dma_strobe_r)
			wcnt_r <= wcnt_r + 9'h001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_apb_no_wait: assert property (acc |-> pready) else $error("pready low");
	chk_bad_addr: assert property (acc && bad |-> pslverr) else $error("no slave error");
	chk_good_addr: assert property (acc && !bad |-> !pslverr) else $error("false slave error");
	chk_cmd_req: assert property (go |=> dmarq_r) else $error("no request");
	chk_other_op: assert property (cmd_valid && cmd_ready && cmd_opcode != 8'hEE |=> !dmarq_r && !busy)
		else $error("stray request");
	chk_idle_ready: assert property (!busy |-> cmd_ready) else $error("idle not ready");
	chk_pause_hold: assert property (hold |=> $stable(low_idx)) else $error("index moved");
	chk_pause_quiet: assert property (hold |=> !dma_strobe_r) else $error("strobe in pause");
	chk_pause_drop: assert property (hold |-> ##[1:2] !dmarq_r) else $error("request kept");
	chk_word_cap: assert property (dma_strobe_r |-> wcnt_r < 9'h100) else $error("over 256");
	chk_rst_quiet: assert property ($rose(rst_b) |-> !dmarq_r && !dma_strobe_r) else $error("rst");
endmodule // idw_mon
bind idw_table idw_mon u_mon (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
	.cmd_opcode(cmd_opcode), .cmd_ready(cmd_ready), .low_idx(low_idx), .dmarq_r(dmarq_r),
	.dmack_b(dmack_b), .dma_pause(dma_pause), .dma_strobe_r(dma_strobe_r), .busy(busy));

// >>> sim/tb_idw_table.sv
// tb_idw_table.sv: self-checking bench for idw_table
// assumes idw_host model and the bound idw_mon checker
`timescale 1ns/1ps
`include "idw_defs.vh"
`define IDW_CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_idw_table;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg cmd_valid = 1'b0;
	reg [7:0] cmd_opcode = 8'h00;
	reg slow = 1'b0;
	wire pready, pslverr, cmd_ready, dmarq_r, dmack_b, dma_pause, dma_strobe_r, busy;
	wire [31:0] prdata;
	wire [7:0] low_idx;
	wire [15:0] dma_data_r;
	wire [15:0] low_word = {8'hC3, low_idx};
	reg [31:0] rd;
	reg er;
	reg [31:0] sh [0:8];
	reg [15:0] got [0:255];
	integer err_total = 0;
	integer total_checks = 0;
	integer n = 0;
	integer i;
	// wr nibble, address, data or expected read
	reg [47:0] rows [0:18] = '{48'h0_000_00000107, 48'h0_004_00000407, 48'h0_008_00000203,
		48'h0_00C_00000078, 48'h0_010_00000078, 48'h0_014_000000B4, 48'h0_018_00000078,
		48'h0_01C_000E0100, 48'h1_000_00000207, 48'h1_004_00000203, 48'h1_008_00000103,
		48'h1_00C_00000096, 48'h1_010_000000B4, 48'h1_014_000000F0, 48'h1_018_000000B4,
		48'h1_01C_00060200, 48'h1_020_5A5A0006, 48'h0_000_00000207, 48'h0_020_5A5A0006};
	idw_table dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_ready(cmd_ready),
		.low_idx(low_idx), .low_word(low_word), .dmarq_r(dmarq_r), .dmack_b(dmack_b),
		.dma_pause(dma_pause), .dma_data_r(dma_data_r), .dma_strobe_r(dma_strobe_r), .busy(busy));
	idw_host u_host (.clk(clk), .rst_b(rst_b), .dmarq_r(dmarq_r), .slow(slow),
		.dmack_b(dmack_b), .dma_pause(dma_pause));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (dma_strobe_r === 1'b1) begin
		got[n[7:0]] <= dma_data_r;
		n <= n + 1;
	end
	function [15:0] ew(input [7:0] k);
		case (k)
		`IDW_W51: ew = {sh[2][15:8], 8'h00};
		`IDW_W64: ew = {14'h0, sh[2][1:0]};
		`IDW_W62, `IDW_W63, `IDW_W65, `IDW_W66, `IDW_W67, `IDW_W68: ew = sh[k - 8'h3E][15:0];
		`IDW_W71: ew = sh[7][15:0];
		`IDW_W72: ew = sh[7][31:16];
		`IDW_W73: ew = sh[8][15:0];
		default: ew = k < 8'h3E ? {8'hC3, k} : (k[7:5] == 3'h4 ? sh[8][31:16] : 16'h0000);
		endcase
	endfunction
	task apb(input w, input [11:0] a, input [31:0] d);
		integer t;
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			t = 0;
			do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
			if (pready !== 1'b1) err_total++;
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			if (w && a < 12'h024) sh[a[5:2]] = d;
		end
	endtask
	task cmd(input [7:0] op);
		integer t;
		begin
			n = 0;
			@(posedge clk);
			cmd_valid <= 1'b1;
			cmd_opcode <= op;
			@(posedge clk);
			cmd_valid <= 1'b0;
			t = 0;
			do @(posedge clk); while ((busy !== 1'b0 || n < 256) && op == 8'hEE && ++t < 3000);
		end
	endtask
	task ident;
		begin
			cmd(`IDW_OP_ID_DMA);
			`IDW_CHK(n, 256)
			for (i = 0; i < 256; i++) if (i != 53) `IDW_CHK(got[i], ew(i))
			`IDW_CHK(got[53][1], 1'b1)
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d errors %0d", total_checks, err_total);
			if (err_total == 0 && total_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#200000;
		err_total++;
		complete_run;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 19; i++) begin
			apb(rows[i][44], rows[i][43:32], rows[i][31:0]);
			if (!rows[i][44]) `IDW_CHK(rd, rows[i][31:0])
		end
		ident;
		slow <= 1'b1;
		ident;
		slow <= 1'b0;
		cmd(8'hEC);
		repeat (4) @(posedge clk);
		`IDW_CHK(dmarq_r, 1'b0)
		apb(1'b1, 12'h030, 32'h0000_1234);
		`IDW_CHK(er, 1'b1)
		apb(1'b0, 12'h030, 32'h0);
		`IDW_CHK(rd, 32'h0)
		for (i = 1; i < 7; i++) apb(1'b1, i * 4, i == 1 ? 32'h0101 : (i == 2 ? 32'h0200 : 32'h0));
		apb(1'b0, `IDW_A_W53, 32'h0);
		`IDW_CHK(rd[1], 1'b0)
		apb(1'b1, `IDW_A_PIOFC, 32'h0000_0078);
		apb(1'b0, `IDW_A_W53, 32'h0);
		`IDW_CHK(rd[1], 1'b1)
		ident;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, `IDW_A_SWDMA, 32'h0);
		`IDW_CHK(rd[15:0], `IDW_RST_SWDMA)
		`IDW_CHK(dmarq_r, 1'b0)
		complete_run;
	end
endmodule // tb_idw_table
